//--- rtl/ncp_ctrl.sv
// nand flash controller: avalon register slave driving the flash pins
`timescale 1ns/100ps
`default_nettype none
`include "ncp_params.svh"
module ncp_ctrl import ncp_pkg::*; #(
    parameter bit WIDE = 1'b0                // 1 for the word-wide part
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic [4:0]  AVS_ADDRESS,     // byte address
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [15:0] NAND_IO_IN,
    output logic [15:0]      NAND_IO_OUT,
    output logic             NAND_IO_OE_N,
    output logic             NAND_CLE,
    output logic             NAND_ALE,
    output logic             NAND_CE_N,
    output logic             NAND_WE_N,
    output logic             read_strobe_n,
    output logic             NAND_WP_N,
    output logic             NAND_SPARE_SKIP, // static spare-area select
    input  wire logic        NAND_RB          // high when ready
);
    // command legality for this part
    function automatic logic cmd_legal(input logic [7:0] c);
        unique case (c)
            `NCP_CMD_READ_A, `NCP_CMD_READ_SP, `NCP_CMD_IDENT, `NCP_CMD_RESET,
            `NCP_CMD_PROG, `NCP_CMD_PROG_GO, `NCP_CMD_COPY_GO, `NCP_CMD_ERASE,
            `NCP_CMD_ERASE_GO, `NCP_CMD_STATUS: cmd_legal = 1'b1;   // R12 R13 R15
            `NCP_CMD_READ_B: cmd_legal = !WIDE;                     // R17
            default:         cmd_legal = 1'b0;                      // R18
        endcase
    endfunction

    // number of address cycles following a command
    function automatic logic [1:0] addr_cycles(input logic [7:0] c);
        unique case (c)
            `NCP_CMD_READ_A, `NCP_CMD_READ_B, `NCP_CMD_READ_SP,
            `NCP_CMD_PROG:   addr_cycles = 2'd3;                    // R14
            `NCP_CMD_ERASE:  addr_cycles = 2'd2;                    // R15
            `NCP_CMD_IDENT:  addr_cycles = 2'd1;
            default:         addr_cycles = 2'd0;
        endcase
    endfunction

    ncp_seq_t     st_q, st_d;                 // sequencer state
    logic [2:0]   ctrl_q, ctrl_d;             // control register
    logic [24:0]  addr_q, addr_d;             // flash address, bit 8 unused
    logic [7:0]   cmd_q, cmd_d;               // last command sent
    logic         err_q, err_d;               // sticky refusal flag
    logic [1:0]   left_q, left_d;             // address cycles still to go
    logic [1:0]   aidx_q, aidx_d;             // which address byte is next
    logic         erase_q, erase_d;           // row-only addressing
    logic [31:0]  rdat_q, rdat_d;             // bus read data
    logic         rb_q;                       // sampled ready line

    logic         cyc_start, cyc_read, cyc_cmd, cyc_addr, cyc_done;
    logic [15:0]  cyc_wdata, cyc_rdata;
    logic         err_set;
    logic [7:0]   abyte;

    // ready line is an open-drain status pin, sampled each cycle
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rb_q <= 1'b1;
        end else begin
            rb_q <= NAND_RB;                      // R01 R02
        end
    end

    // address byte for the current cycle; A8 is never put on the pins
    always_comb begin
        unique case (aidx_q)
            2'd0:    abyte = addr_q[7:0];         // R04 R05
            2'd1:    abyte = addr_q[16:9];        // R04 R06
            default: abyte = addr_q[24:17];       // R04
        endcase
    end

    // sequencer and register file
    always_comb begin
        st_d      = st_q;
        ctrl_d    = ctrl_q;
        addr_d    = addr_q;
        cmd_d     = cmd_q;
        err_set   = 1'b0;
        left_d    = left_q;
        aidx_d    = aidx_q;
        erase_d   = erase_q;
        rdat_d    = rdat_q;
        cyc_start = 1'b0;
        cyc_read  = 1'b0;
        cyc_cmd   = 1'b0;
        cyc_addr  = 1'b0;
        cyc_wdata = '0;
        unique case (st_q)
            NCP_S_IDLE: begin
                if (AVS_WRITE) begin
                    st_d = NCP_S_FIN;
                    unique case (AVS_ADDRESS)
                        `NCP_REG_CTRL: ctrl_d = AVS_WRITEDATA[2:0];
                        `NCP_REG_ADDR: addr_d = AVS_WRITEDATA[24:0];
                        `NCP_REG_CMD: begin
                            // undefined codes, and all but reset and status while busy, are refused
                            if (!cmd_legal(AVS_WRITEDATA[7:0])) begin              // R18
                                err_set = 1'b1;
                            end else if (!rb_q && AVS_WRITEDATA[7:0] != `NCP_CMD_RESET &&
                                         AVS_WRITEDATA[7:0] != `NCP_CMD_STATUS) begin
                                err_set = 1'b1;                                     // R16
                            end else begin
                                st_d      = NCP_S_CMD;
                                cmd_d     = AVS_WRITEDATA[7:0];
                                cyc_start = 1'b1;
                                cyc_cmd   = 1'b1;                                   // R11
                                cyc_wdata = {8'h00, AVS_WRITEDATA[7:0]};           // R08
                                left_d    = addr_cycles(AVS_WRITEDATA[7:0]);
                                erase_d   = (AVS_WRITEDATA[7:0] == `NCP_CMD_ERASE);
                                aidx_d    = (AVS_WRITEDATA[7:0] == `NCP_CMD_ERASE) ? 2'd1 : 2'd0; // R15
                            end
                        end
                        `NCP_REG_DATA: begin
                            // data cycle: both latches low
                            st_d      = NCP_S_DATA;
                            cyc_start = 1'b1;
                            cyc_wdata = WIDE ? AVS_WRITEDATA[15:0]
                                             : {8'h00, AVS_WRITEDATA[7:0]};       // R09
                        end
                        `NCP_REG_STATUS: ;                                          // error cleared below
                        default: ;                                                  // unmapped: ignored
                    endcase
                end else if (AVS_READ) begin
                    st_d = NCP_S_FIN;
                    unique case (AVS_ADDRESS)
                        `NCP_REG_CTRL:   rdat_d = {29'h0, ctrl_q};
                        `NCP_REG_ADDR:   rdat_d = {7'h0, addr_q};
                        `NCP_REG_CMD:    rdat_d = {24'h0, cmd_q};
                        `NCP_REG_STATUS: rdat_d = {29'h0, ctrl_q[`NCP_CTRL_WP_REL], err_q, rb_q};
                        `NCP_REG_DATA: begin
                            // a read word costs one read strobe on the pins
                            st_d      = NCP_S_DATA;
                            cyc_start = 1'b1;
                            cyc_read  = 1'b1;
                        end
                        default:         rdat_d = 32'h0;                            // unmapped reads zero
                    endcase
                end
            end
            NCP_S_CMD, NCP_S_ADDR: begin
                // after the command, address cycles follow immediately
                if (cyc_done) begin
                    if (left_q != 2'd0) begin
                        st_d      = NCP_S_ADDR;
                        cyc_start = 1'b1;
                        cyc_addr  = 1'b1;                                           // R11 R14
                        cyc_wdata = {8'h00, abyte};                                 // R08
                        left_d    = left_q - 2'd1;
                        aidx_d    = aidx_q + 2'd1;                                  // R05
                    end else begin
                        st_d = NCP_S_FIN;
                    end
                end
            end
            NCP_S_DATA: begin
                if (cyc_done) begin
                    st_d   = NCP_S_FIN;
                    rdat_d = WIDE ? {16'h0, cyc_rdata} : {24'h0, cyc_rdata[7:0]};   // R09
                end
            end
            NCP_S_FIN: st_d = NCP_S_IDLE;
            default:   st_d = NCP_S_IDLE;     // unused codes recover to idle
        endcase
        // sticky error: a new refusal wins over a write-one clear
        err_d = err_set | (err_q & !(st_q == NCP_S_IDLE && AVS_WRITE &&
                                     AVS_ADDRESS == `NCP_REG_STATUS &&
                                     AVS_WRITEDATA[`NCP_STAT_ERROR]));
    end

    // register stage
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_q    <= NCP_S_IDLE;
            ctrl_q  <= `NCP_CTRL_RESET;
            addr_q  <= '0;
            cmd_q   <= `NCP_CMD_READ_A;
            err_q   <= 1'b0;
            left_q  <= '0;
            aidx_q  <= '0;
            erase_q <= 1'b0;
            rdat_q  <= '0;
        end else begin
            st_q    <= st_d;
            ctrl_q  <= ctrl_d;
            addr_q  <= addr_d;
            cmd_q   <= cmd_d;
            err_q   <= err_d;
            left_q  <= left_d;
            aidx_q  <= aidx_d;
            erase_q <= erase_d;
            rdat_q  <= rdat_d;
        end
    end

    // one strobe cycle engine shared by every kind of cycle
    ncp_cycle #(
        .CW      (4)
    ) u_cycle (
        .clk     (REF_CLK),
        .rst     (RST),
        .start   (cyc_start),
        .is_read (cyc_read),
        .is_cmd  (cyc_cmd),
        .is_addr (cyc_addr),
        .wdata   (cyc_wdata),
        .io_in   (NAND_IO_IN),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .we_n    (NAND_WE_N),
        .re_n    (read_strobe_n),
        .cle     (NAND_CLE),
        .ale     (NAND_ALE),
        .io_out  (NAND_IO_OUT),
        .io_oe_n (NAND_IO_OE_N)
    );

    // answer comes only in the finish state, entered on the same edge that registers the data
    assign AVS_WAITREQUEST = (st_q != NCP_S_FIN);
    assign AVS_READDATA    = rdat_q;
    // chip select low during any sequence, or held by software across a page
    assign NAND_CE_N       = !((st_q != NCP_S_IDLE && st_q != NCP_S_FIN) ||
                               ctrl_q[`NCP_CTRL_CE_HOLD]);                          // R10 R24
    // protect stays asserted until software releases it
    assign NAND_WP_N       = ctrl_q[`NCP_CTRL_WP_REL];                              // R23
    assign NAND_SPARE_SKIP = ctrl_q[`NCP_CTRL_SPARE];                               // R03
endmodule
`default_nettype wire

//--- rtl/ncp_params.svh
// constants of the nand command and address port controller
//
// Summary of operation
// [R01] device holds busy low during long operations
// [R02] busy line is open drain, never floats
// [R03] static spare select: low includes, high skips
// [R04] address cycles: A0-A7, A9-A16, A17-A24
// [R05] column first, then low row, high row
// [R06] A8 never sent; 00h/01h pick half
// [R07] device ignores surplus address cycles
// [R08] upper eight lines low on command/address
// [R09] word-wide data uses all sixteen lines
// [R10] write strobe pulsed low with select low
// [R11] command latch, address latch, else data
// [R12] single-cycle commands 00h/01h/50h/90h/FFh/70h
// [R13] two-cycle ops: 80h-10h, 00h-8Ah, confirm executes
// [R14] read and program take three address cycles
// [R15] erase: 60h, two row cycles, D0h
// [R16] while busy only FFh and 70h accepted
// [R17] 01h exists only on byte-wide part
// [R18] controller never sends undefined command codes
// [R19] 65536 pages of 528 bytes or 264 words
// [R20] spare columns 512-527 or 256-263
// [R21] erase only whole blocks, 2048 blocks
// [R22] read strobe fall presents next word
// [R23] write protect low blocks program and erase
// [R24] busy device ignores deselect until done
// [R25] device model holds busy for configured time
// [R26] reset command aborts, readies, selects first half
`ifndef NCP_PARAMS_SVH
`define NCP_PARAMS_SVH

// clock and strobe timing
`define NCP_CLK_NS        5
`define NCP_T_LOW_NS      25
`define NCP_T_HIGH_NS     20
`define NCP_T_LOW_CYC     ((`NCP_T_LOW_NS + `NCP_CLK_NS - 1) / `NCP_CLK_NS)
`define NCP_T_HIGH_CYC    ((`NCP_T_HIGH_NS + `NCP_CLK_NS - 1) / `NCP_CLK_NS)

// register byte offsets
`define NCP_REG_CTRL      5'h00
`define NCP_REG_ADDR      5'h04
`define NCP_REG_CMD       5'h08
`define NCP_REG_DATA      5'h0c
`define NCP_REG_STATUS    5'h10

// control fields
`define NCP_CTRL_WP_REL   0
`define NCP_CTRL_SPARE    1
`define NCP_CTRL_CE_HOLD  2
`define NCP_CTRL_RESET    3'h0

// status fields
`define NCP_STAT_READY    0
`define NCP_STAT_ERROR    1
`define NCP_STAT_WP_REL   2

// command codes
`define NCP_CMD_READ_A    8'h00
`define NCP_CMD_READ_B    8'h01
`define NCP_CMD_READ_SP   8'h50
`define NCP_CMD_IDENT     8'h90
`define NCP_CMD_RESET     8'hff
`define NCP_CMD_PROG      8'h80
`define NCP_CMD_PROG_GO   8'h10
`define NCP_CMD_COPY_GO   8'h8a
`define NCP_CMD_ERASE     8'h60
`define NCP_CMD_ERASE_GO  8'hd0
`define NCP_CMD_STATUS    8'h70

`endif

//--- rtl/ncp_pkg.sv
// types of the nand command and address port controller
package ncp_pkg;

    // sequencer states of the controller
    typedef enum logic [2:0] {
        NCP_S_IDLE = 3'b000,
        NCP_S_CMD  = 3'b001,
        NCP_S_ADDR = 3'b010,
        NCP_S_DATA = 3'b011,
        NCP_S_FIN  = 3'b100
    } ncp_seq_t;

    // phases of one strobe cycle on the pins
    typedef enum logic [1:0] {
        NCP_P_IDLE  = 2'b00,
        NCP_P_SETUP = 2'b01,
        NCP_P_LOW   = 2'b10,
        NCP_P_HIGH  = 2'b11
    } ncp_phase_t;

endpackage

//--- rtl/ncp_cycle.sv
// one bus cycle on the flash pins: command, address, data write or data read
`timescale 1ns/100ps
`default_nettype none
`include "ncp_params.svh"
module ncp_cycle import ncp_pkg::*; #(
    parameter int CW = 4                     // width of the phase counter
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,          // one-cycle request
    input  wire logic        is_read,        // read strobe instead of write strobe
    input  wire logic        is_cmd,         // command latch during the cycle
    input  wire logic        is_addr,        // address latch during the cycle
    input  wire logic [15:0] wdata,          // value to drive
    input  wire logic [15:0] io_in,          // pins as sampled
    output logic             done,           // one-cycle pulse at the end
    output logic [15:0]      rdata,          // captured read word
    output logic             we_n,
    output logic             re_n,
    output logic             cle,
    output logic             ale,
    output logic [15:0]      io_out,
    output logic             io_oe_n         // low while this end drives
);
    localparam logic [CW-1:0] LOW_CNT  = CW'(`NCP_T_LOW_CYC - 1);
    localparam logic [CW-1:0] HIGH_CNT = CW'(`NCP_T_HIGH_CYC - 1);

    ncp_phase_t    ph_q, ph_d;               // current phase
    logic [CW-1:0] cnt_q, cnt_d;             // cycles left in the phase
    logic          rd_q, rd_d;               // cycle is a read
    logic          cle_q, cle_d;
    logic          ale_q, ale_d;
    logic [15:0]   out_q, out_d;             // driven value
    logic [15:0]   rdat_q, rdat_d;           // captured read value
    logic          done_d;

    // phase sequencing: setup, strobe low, strobe high
    always_comb begin
        ph_d   = ph_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        cle_d  = cle_q;
        ale_d  = ale_q;
        out_d  = out_q;
        rdat_d = rdat_q;
        done_d = 1'b0;
        unique case (ph_q)
            NCP_P_IDLE: begin
                cle_d = 1'b0;
                ale_d = 1'b0;
                if (start) begin
                    // latches settle one cycle before the strobe falls
                    ph_d  = NCP_P_SETUP;
                    rd_d  = is_read;
                    cle_d = is_cmd;             // R11
                    ale_d = is_addr;            // R11
                    out_d = wdata;
                end
            end
            NCP_P_SETUP: begin
                ph_d  = NCP_P_LOW;
                cnt_d = LOW_CNT;
            end
            NCP_P_LOW: begin
                if (cnt_q == '0) begin
                    // read data sampled late in the low phase, after access time
                    if (rd_q) begin
                        rdat_d = io_in;         // R22
                    end
                    ph_d  = NCP_P_HIGH;
                    cnt_d = HIGH_CNT;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            NCP_P_HIGH: begin
                // value and latches held through high phase for hold time
                if (cnt_q == '0) begin
                    ph_d   = NCP_P_IDLE;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
    end

    // register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q   <= NCP_P_IDLE;
            cnt_q  <= '0;
            rd_q   <= 1'b0;
            cle_q  <= 1'b0;
            ale_q  <= 1'b0;
            out_q  <= '0;
            rdat_q <= '0;
            done   <= 1'b0;
        end else begin
            ph_q   <= ph_d;
            cnt_q  <= cnt_d;
            rd_q   <= rd_d;
            cle_q  <= cle_d;
            ale_q  <= ale_d;
            out_q  <= out_d;
            rdat_q <= rdat_d;
            done   <= done_d;
        end
    end

    // strobes decoded from the registered phase
    assign we_n    = !(ph_q == NCP_P_LOW && !rd_q);   // R10
    assign re_n    = !(ph_q == NCP_P_LOW && rd_q);    // R22
    assign io_oe_n = (ph_q == NCP_P_IDLE) || rd_q;
    assign cle     = cle_q;
    assign ale     = ale_q;
    assign io_out  = out_q;
    assign rdata   = rdat_q;
endmodule
`default_nettype wire

//--- dv/ncp_ctrl_assertions.sv
// concurrent checks on the pins and bus of the flash controller
`timescale 1ns/100ps
`default_nettype none
module ncp_ctrl_chk #(
    parameter bit WIDE = 1'b0                // word-wide part when set
) (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [15:0] NAND_IO_OUT,
    input wire logic        NAND_IO_OE_N,
    input wire logic        NAND_CLE,
    input wire logic        NAND_ALE,
    input wire logic        NAND_CE_N,
    input wire logic        NAND_WE_N,
    input wire logic        read_strobe_n,
    input wire logic        NAND_RB
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // the write strobe stays low five cycles, then rises
    chk_we_width: assert property ($fell(NAND_WE_N) |-> !NAND_WE_N [*5] ##1 NAND_WE_N)
        else $error("write strobe width off");
    // the read strobe stays low five cycles with the pins released
    chk_re_width: assert property ($fell(read_strobe_n) |-> (!read_strobe_n && NAND_IO_OE_N) [*5] ##1 read_strobe_n)
        else $error("read strobe width off");
    // a bus answer lasts one cycle only
    chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    chk_latch_excl: assert property (!(NAND_CLE && NAND_ALE))
        else $error("both latches high");
    // command and address bytes leave the upper lines low
    chk_upper_zero: assert property ((NAND_CLE || NAND_ALE) |-> NAND_IO_OUT[15:8] == 8'h00)
        else $error("upper lines not low");
    chk_we_select: assert property (!NAND_WE_N |-> !NAND_CE_N && !NAND_IO_OE_N)
        else $error("write strobe without select");
    // latch kind and value stand until the strobe has risen
    chk_latch_stable: assert property (!NAND_WE_N |=> $stable(NAND_CLE) && $stable(NAND_ALE) && $stable(NAND_IO_OUT))
        else $error("latch lines moved at strobe");
    // a busy device is sent only reset or status
    chk_busy_refuse: assert property ($rose(NAND_CLE) && !$past(NAND_RB, 2) && !$past(NAND_RB) |-> NAND_IO_OUT[7:0] inside {8'hff, 8'h70})
        else $error("command sent while busy");
    cov_erase: cover property ($rose(NAND_CLE) && NAND_IO_OUT[7:0] == 8'h60);
    cov_read: cover property ($fell(read_strobe_n));
    cov_busy_cmd: cover property (!NAND_RB && NAND_CLE);
endmodule
bind ncp_ctrl ncp_ctrl_chk #(.WIDE(WIDE)) ncp_ctrl_chk_i (.REF_CLK, .RST, .AVS_WAITREQUEST, .NAND_IO_OUT, .NAND_IO_OE_N,
    .NAND_CLE, .NAND_ALE, .NAND_CE_N, .NAND_WE_N, .read_strobe_n, .NAND_RB);
`default_nettype wire

//--- dv/ncp_flash_model.sv
// behavioural byte-wide flash device seen from its pins
`timescale 1ns/100ps
`default_nettype none
module ncp_flash_model #(
    parameter int BUSY_NS = 402              // busy time; off the clock grid so ready never races an edge
) (
    input  wire logic [15:0] io_out,
    input  wire logic        cle,
    input  wire logic        ale,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        re_n,
    input  wire logic        wp_n,
    output logic [15:0]      io_in,
    output logic             rb
);
    logic [7:0] cmd_q;                       // last command taken
    logic [7:0] ab [3];                      // address bytes taken
    int         acnt;                        // address cycles taken
    int         need;                        // address cycles the command uses
    logic [9:0] col;                         // column counter, 528 columns
    logic       half_b;                      // second register half
    event       go;
    initial begin
        {cmd_q, acnt, need, col, half_b, rb, io_in} = {8'h00, 32'd0, 32'd0, 10'h000, 1'b0, 1'b1, 16'ha5c3};
    end
    // busy interval; deselect does not cut it short
    always @(go) begin : busy_blk
        rb = 1'b0;
        #(BUSY_NS);
        rb = 1'b1;
    end
    // latch on the rising write strobe of a selected part
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            if (rb || io_out[7:0] inside {8'hff, 8'h70}) begin
                cmd_q = io_out[7:0];
                acnt = 0;
                need = (cmd_q inside {8'h00, 8'h01, 8'h50, 8'h80}) ? 3 : (cmd_q == 8'h60) ? 2 : (cmd_q == 8'h90);
                if (cmd_q inside {8'h00, 8'h01}) half_b = cmd_q[0];
                if (cmd_q == 8'hff) begin
                    disable busy_blk;
                    rb = 1'b1;
                    half_b = 1'b0;
                end
                // erase works on whole blocks; protect blocks program, erase and copy, not the busy of a read
                if (wp_n && cmd_q inside {8'h10, 8'hd0, 8'h8a}) ->go;
            end
        end else if (!ce_n && ale && acnt < need) begin
            ab[acnt] = io_out[7:0];
            acnt++;
            if (acnt == 1) col = (cmd_q == 8'h50) ? 10'd512 + ab[0][3:0] : {1'b0, half_b, ab[0]};
            if (acnt == 3 && cmd_q != 8'h80) ->go;
        end
    end
    // each falling read strobe presents the next column
    always @(negedge re_n) begin
        if (!ce_n) begin
            io_in = {col[7:0], col[7:0] ^ 8'h5a};
            col = (col == 10'd527) ? 10'd0 : col + 10'd1;
        end
    end
    // after the hold time the lines no longer show the old word
    always @(posedge re_n) begin
        #8 io_in = ~io_in;
    end
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking testbench of the flash controller
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        REF_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [4:0]  AVS_ADDRESS = 5'h00;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic [15:0] NAND_IO_OUT, io_dev, io_wire;
    logic        NAND_IO_OE_N, NAND_CLE, NAND_ALE, NAND_CE_N, NAND_WE_N;
    logic        read_strobe_n, NAND_WP_N, NAND_SPARE_SKIP, NAND_RB;
    logic [31:0] rd;                         // last read data
    int          mismatches = 0;
    int          compares = 0;
    // the controller's drive wins while its enable is low
    assign io_wire = NAND_IO_OE_N ? io_dev : NAND_IO_OUT;
    always #2.5 REF_CLK = ~REF_CLK;
    ncp_ctrl #(.WIDE(1'b0)) ncp_ctrl_i (.REF_CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_READDATA, .AVS_WAITREQUEST, .NAND_IO_IN(io_wire), .NAND_IO_OUT, .NAND_IO_OE_N, .NAND_CLE,
        .NAND_ALE, .NAND_CE_N, .NAND_WE_N, .read_strobe_n, .NAND_WP_N, .NAND_SPARE_SKIP, .NAND_RB);
    ncp_flash_model ncp_flash_model_i (.io_out(io_wire), .cle(NAND_CLE), .ale(NAND_ALE), .ce_n(NAND_CE_N),
        .we_n(NAND_WE_N), .re_n(read_strobe_n), .wp_n(NAND_WP_N), .io_in(io_dev), .rb(NAND_RB));
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 1000);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (n >= 1000) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    // poll status until the device reports ready
    task automatic wait_ready();
        for (int i = 0; i < 100; i++) begin
            bus(1'b0, 5'h10, 32'h0);
            if (rd[0] === 1'b1) return;
        end
        mismatches++;
        report_and_stop();
    endtask
    task automatic s_reset_ctrl();
        bus(1'b0, 5'h10, 32'h0);
        check(rd, 32'h1);
        bus(1'b0, 5'h14, 32'h0);
        check(rd, 32'h0);
        check(32'({NAND_WP_N, NAND_SPARE_SKIP}), 32'h0);
        bus(1'b1, 5'h00, 32'h3);
        check(32'({NAND_WP_N, NAND_SPARE_SKIP}), 32'h3);
        bus(1'b1, 5'h00, 32'h1);
        check(32'(NAND_SPARE_SKIP), 32'h0);
    endtask
    task automatic s_program();
        bus(1'b1, 5'h04, 32'h00ac6812);
        bus(1'b1, 5'h08, 32'h80);
        check(32'(ncp_flash_model_i.acnt), 32'h3);
        check(32'({ncp_flash_model_i.ab[0], ncp_flash_model_i.ab[1], ncp_flash_model_i.ab[2]}), 32'h123456);
        bus(1'b1, 5'h08, 32'h10);
        check(32'(NAND_RB), 32'h0);
        bus(1'b1, 5'h08, 32'h80);
        bus(1'b0, 5'h10, 32'h0);
        check(rd & 32'h3, 32'h2);
        bus(1'b1, 5'h08, 32'h70);
        check(32'(ncp_flash_model_i.cmd_q), 32'h70);
        bus(1'b1, 5'h10, 32'h2);
        wait_ready();
        check(rd, 32'h5);
    endtask
    task automatic s_erase_refuse();
        bus(1'b1, 5'h08, 32'h60);
        check(32'({ncp_flash_model_i.acnt[7:0], ncp_flash_model_i.ab[0], ncp_flash_model_i.ab[1]}), 32'h023456);
        bus(1'b1, 5'h08, 32'hd0);
        check(32'(NAND_RB), 32'h0);
        wait_ready();
        bus(1'b1, 5'h08, 32'h33);
        bus(1'b0, 5'h10, 32'h0);
        check(rd, 32'h7);
        check(32'(ncp_flash_model_i.cmd_q), 32'hd0);
        bus(1'b1, 5'h10, 32'h2);
    endtask
    task automatic s_read_reset();
        bus(1'b1, 5'h08, 32'h01);
        wait_ready();
        check(32'(ncp_flash_model_i.half_b), 32'h1);
        bus(1'b1, 5'h08, 32'h00);
        wait_ready();
        bus(1'b0, 5'h0c, 32'h0);
        check(rd[7:0], 8'h48);
        bus(1'b0, 5'h0c, 32'h0);
        check(rd[7:0], 8'h49);
        bus(1'b1, 5'h08, 32'h90);
        check(32'({ncp_flash_model_i.acnt[7:0], ncp_flash_model_i.ab[0]}), 32'h0112);
        bus(1'b1, 5'h08, 32'h60);
        bus(1'b1, 5'h08, 32'hd0);
        bus(1'b1, 5'h08, 32'hff);
        check(32'(NAND_RB), 32'h1);
        bus(1'b0, 5'h08, 32'h0);
        check(rd, 32'hff);
    endtask
    initial begin
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        s_reset_ctrl();
        s_program();
        s_erase_refuse();
        s_read_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
